/* sse_step_engine.sv */
// step sequence engine: a bank of one-bit step devices changed by rungs
// one operation per accepted cycle: a chain initialise or a whole rung
// of step tests and step advances; results stand one cycle later
// assumes one rung per accepted cycle, issued in program order by the
// scan sequencer on the same clock; no synchroniser is needed
// assumes the sequencer keeps a conditional branch on rungs of its own,
// since a combined branch rung is not refused here
`include "sse_consts.svh"

module sse_step_engine
   import sse_pkg::*;
#(
   parameter int NUM_STEPS = `SSE_NUM_STEPS,
   parameter int NUM_INIT = `SSE_NUM_INIT,
   parameter int NUM_ADV = `SSE_NUM_ADV,
   parameter int NUM_TESTS = `SSE_MAX_TESTS,
   parameter int IW = $clog2(NUM_STEPS),
   parameter int SW = $clog2(NUM_INIT)
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic op_valid,
   input wire sse_op_t op_code,
   input wire logic rung_in,
   input wire logic [SW-1:0] init_slot,
   input wire logic [IW-1:0] init_start,
   input wire logic [6:0] init_len,
   input wire logic [NUM_TESTS-1:0] test_en,
   input wire logic [NUM_TESTS*IW-1:0] test_idx,
   input wire logic test_par,
   input wire logic [NUM_ADV-1:0] adv_en,
   input wire logic [NUM_ADV*IW-1:0] adv_idx,
   output logic done,
   output logic rung_out,
   output logic [NUM_TESTS-1:0] test_out,
   output logic init_fired,
   output logic len_err,
   output logic [NUM_STEPS-1:0] steps
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic done;
      logic rung_out;
      logic [NUM_TESTS-1:0] test_out;
      logic init_fired;
      logic len_err;
      logic [NUM_INIT-1:0] init_prev;
      logic [NUM_STEPS-1:0] steps;
   } sse_state_t;

   sse_state_t q;
   sse_state_t d;

   // ****************************************************************
   // limitations
   // ****************************************************************
   // the rung network is either all series or all parallel; a mixed
   // network must be split by the sequencer into separate rungs
   // a chain length outside 1 to 64 touches no step, only the slot's edge
   // memory, and on an OFF to ON input pulses the length error, so software sees the refusal without damage
   // every initialise slot keeps its own edge memory; two slots never
   // share one, or one would eat the other's rising edge
   // the whole bank is one register, traded for single-cycle rungs

   function automatic logic [IW-1:0] sse_pick(
      input logic [NUM_TESTS*IW-1:0] vec,
      input int k
   );
      sse_pick = vec[k*IW +: IW];
   endfunction

   function automatic logic [IW-1:0] sse_pick_adv(
      input logic [NUM_ADV*IW-1:0] vec,
      input int k
   );
      sse_pick_adv = vec[k*IW +: IW];
   endfunction

   // ****************************************************************
   // operand checks
   // ****************************************************************
   function automatic logic sse_len_legal(
      input logic [6:0] len
   );
      sse_len_legal = (len >= `SSE_MIN_CHAIN) && (len <= `SSE_MAX_CHAIN);
   endfunction

   // true when bank position pos lies inside the chain; the end is
   // reckoned in int so a chain past the bank end clips, never wraps
   function automatic logic sse_in_chain(
      input int pos,
      input logic [IW-1:0] start,
      input logic [6:0] len
   );
      int lo;
      int hi;
      lo = int'(start);
      hi = lo + int'(len);
      sse_in_chain = (pos >= lo) && (pos < hi);
   endfunction

   // ****************************************************************
   // operand pointers
   // ****************************************************************
   // the flat index buses are cut once here, so every use in the rung
   // logic reads the same pointer
   logic [IW-1:0] test_ptr [NUM_TESTS];
   logic [IW-1:0] adv_ptr [NUM_ADV];

   for (genvar g = 0; g < NUM_TESTS; g++) begin : g_test_ptr
      assign test_ptr[g] = sse_pick(test_idx, g);
   end

   for (genvar g = 0; g < NUM_ADV; g++) begin : g_adv_ptr
      assign adv_ptr[g] = sse_pick_adv(adv_idx, g);
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      logic [NUM_TESTS-1:0] hit;
      logic any_hit;
      logic all_hit;
      logic cond;
      logic len_ok;
      hit = '0;
      any_hit = 1'b0;
      all_hit = 1'b1;
      cond = 1'b0;
      len_ok = 1'b0;
      d = q;
      d.done = 1'b0;
      d.init_fired = 1'b0;
      d.len_err = 1'b0;
      if (op_valid) begin
         d.done = 1'b1;
         case (op_code)
            SSE_OP_INIT: begin
               // output mirrors the input whether or not the chain is touched
               d.rung_out = rung_in;
               d.test_out = '0;
               d.init_prev[init_slot] = rung_in;
               len_ok = sse_len_legal(init_len);
               if (rung_in && !q.init_prev[init_slot]) begin
                  d.len_err = !len_ok;
                  if (len_ok) begin
                     d.init_fired = 1'b1;
                     // a chain running past the bank end is clipped there
                     for (int i = 0; i < NUM_STEPS; i++) begin
                        if (sse_in_chain(i, init_start, init_len)) begin
                           d.steps[i] = 1'b0;
                        end
                     end
                     d.steps[init_start] = 1'b1;
                  end
               end
            end
            SSE_OP_RUNG: begin
               for (int k = 0; k < NUM_TESTS; k++) begin
                  hit[k] = rung_in && test_en[k] &&
                           q.steps[test_ptr[k]];
                  if (test_en[k]) begin
                     any_hit = any_hit | hit[k];
                     all_hit = all_hit & hit[k];
                  end
               end
               // series needs every enabled test, parallel any one; a rung
               // with no test at all is steered by its input alone
               if (test_en == '0) begin
                  cond = rung_in;
               end else if (test_par) begin
                  cond = any_hit;
               end else begin
                  cond = all_hit;
               end
               d.test_out = hit;
               d.rung_out = cond;
               if (cond) begin
                  // clear first so a loop back onto a tested step keeps
                  // that step set
                  for (int k = 0; k < NUM_TESTS; k++) begin
                     if (test_en[k]) begin
                        d.steps[test_ptr[k]] = 1'b0;
                     end
                  end
                  for (int k = 0; k < NUM_ADV; k++) begin
                     if (adv_en[k]) begin
                        d.steps[adv_ptr[k]] = 1'b1;
                     end
                  end
               end
            end
            default: begin
               d.done = 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   // each rung updates the bank before the next rung is read
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q <= '0;
         q.steps <= {NUM_STEPS{`SSE_STEP_RESET}};
      end else begin
         q <= d;
      end
   end

   assign done = q.done;
   assign rung_out = q.rung_out;
   assign test_out = q.test_out;
   assign init_fired = q.init_fired;
   assign len_err = q.len_err;
   assign steps = q.steps;

endmodule // sse_step_engine

/* sse_consts.svh */
// constants of the step sequence engine: lengths, limits, reset values
// assumes it is included by the package and by the engine module
// ****************************************************************
// Summary of operation
// - The chain initialise takes a start step and a length of 1 to 64, clears every step of the chain and sets the start step.
// - The chain initialise acts only on an OFF to ON change of its input, and its rung output equals its input.
// - A step test gives ON only when its input is ON and its step is ON, otherwise OFF.
// - With its input ON a step advance sets its target step and in the same scan clears every step tested on that rung.
// - One rung may carry several step advances, and a true rung sets all of their targets together.
// - A rung holds at most 11 step tests combined in series or in parallel, which allows loops and convergence.
// ****************************************************************
`ifndef SSE_CONSTS_SVH
`define SSE_CONSTS_SVH

`define SSE_NUM_STEPS 256
`define SSE_NUM_INIT 16
`define SSE_NUM_ADV 4
`define SSE_MAX_TESTS 11
`define SSE_MIN_CHAIN 7'h01
`define SSE_MAX_CHAIN 7'h40
`define SSE_STEP_RESET 1'b0

`endif

/* sse_pkg.sv */
// types shared by the step sequence engine and its bench
// assumes sse_consts.svh is on the include path
`include "sse_consts.svh"

package sse_pkg;

   // ****************************************************************
   // rung operation codes
   // ****************************************************************
   typedef enum logic [1:0] {
      SSE_OP_NONE = 2'b00,
      SSE_OP_INIT = 2'b01,
      SSE_OP_RUNG = 2'b10
   } sse_op_t;

endpackage

/* sse_step_engine_assertions.sv */
// checker for the step engine ports
// assumes it is bound to sse_step_engine with default widths
module sse_chk
   import sse_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic op_valid,
   input wire sse_op_t op_code,
   input wire logic rung_in,
   input wire logic [6:0] init_len,
   input wire logic [10:0] test_en,
   input wire logic [3:0] adv_en,
   input wire logic [31:0] adv_idx,
   input wire logic done,
   input wire logic rung_out,
   input wire logic [10:0] test_out,
   input wire logic init_fired,
   input wire logic len_err,
   input wire logic [255:0] steps
);
   // ****************
   // relations
   // ****************
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_init;
      op_valid && op_code == SSE_OP_INIT;
   endsequence
   sequence s_rung;
      op_valid && op_code == SSE_OP_RUNG;
   endsequence
   a_init_follow: assert property (s_init |=> done && rung_out == $past(rung_in))
      else $error("init output wrong");
   a_init_cause: assert property (init_fired |-> $past(rung_in && op_valid))
      else $error("init fired without input");
   a_len_ok: assert property (init_fired || len_err |-> $past(init_len inside {[1:64]}) != len_err)
      else $error("length check wrong");
   a_test_gate: assert property (s_rung |=> (test_out & ~$past(test_en & {11{rung_in}})) == 0)
      else $error("test output without cause");
   a_adv_set: assert property (s_rung ##1 rung_out |-> !$past(adv_en[0]) || steps[$past(adv_idx[7:0])])
      else $error("advance target not set");
   a_par_start: assert property (s_rung ##1 rung_out |-> !$past(adv_en[3]) || steps[$past(adv_idx[31:24])])
      else $error("parallel target not set");
   a_idle_hold: assert property (!op_valid |=> $stable(steps) && !done)
      else $error("steps moved while idle");
endmodule // sse_chk

bind sse_step_engine sse_chk u_chk (
   .clk(clk),
   .reset_n(reset_n),
   .op_valid(op_valid),
   .op_code(op_code),
   .rung_in(rung_in),
   .init_len(init_len),
   .test_en(test_en),
   .adv_en(adv_en),
   .adv_idx(adv_idx),
   .done(done),
   .rung_out(rung_out),
   .test_out(test_out),
   .init_fired(init_fired),
   .len_err(len_err),
   .steps(steps)
);

/* testbench.sv */
// bench of the step engine: rung table, then a reset in mid-run
// assumes sse_pkg and the engine with default parameters
module testbench
   import sse_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      sse_op_t op; logic rin; logic [3:0] sl; logic [7:0] st;
      logic [6:0] ln; logic [10:0] te; logic par; logic [3:0] ae;
      logic [7:0] ab;
   } sse_row_t;
   logic clk = 0, reset_n = 0, op_valid = 0, rung_in = 0, test_par = 0;
   sse_op_t op_code = SSE_OP_NONE;
   logic [3:0] init_slot = '0, adv_en = '0;
   logic [7:0] init_start = '0;
   logic [6:0] init_len = '0;
   logic [10:0] test_en = '0, test_out, e_to;
   logic [87:0] test_idx = '0;
   logic [31:0] adv_idx = '0;
   logic done, rung_out, init_fired, len_err, e_dn, e_r, e_f, e_l;
   logic [255:0] steps, m = '0;
   logic [15:0] mem = '0;
   int n_fail = 0, n_tests = 0, cyc = 0;
   bit have = 0;
   // ****************
   // rows run back to back; each sees the steps left by the one before
   // ****************
   localparam sse_row_t rows [14] = '{
      '{SSE_OP_INIT, 1, 4'h0, 8'h10, 7'h0A, 11'h000, 0, 4'h0, 8'h00},
      '{SSE_OP_INIT, 1, 4'h0, 8'h10, 7'h0A, 11'h000, 0, 4'h0, 8'h00},
      '{SSE_OP_INIT, 0, 4'h0, 8'h10, 7'h0A, 11'h000, 0, 4'h0, 8'h00},
      '{SSE_OP_RUNG, 1, 4'h0, 8'h10, 7'h00, 11'h001, 0, 4'h1, 8'h11},
      '{SSE_OP_RUNG, 1, 4'h0, 8'h10, 7'h00, 11'h003, 1, 4'hF, 8'h20},
      '{SSE_OP_RUNG, 1, 4'h0, 8'h20, 7'h00, 11'h7FF, 0, 4'h1, 8'h00},
      '{SSE_OP_RUNG, 0, 4'h0, 8'h20, 7'h00, 11'h001, 0, 4'h1, 8'h00},
      '{SSE_OP_RUNG, 1, 4'h0, 8'h20, 7'h00, 11'h7FF, 1, 4'h1, 8'h10},
      // loop back: the tested step is also the target and stays set
      '{SSE_OP_RUNG, 1, 4'h0, 8'h10, 7'h00, 11'h001, 0, 4'h1, 8'h10},
      // a branch kept as one rung per path, only one path true
      '{SSE_OP_RUNG, 0, 4'h0, 8'h10, 7'h00, 11'h001, 0, 4'h1, 8'h30},
      '{SSE_OP_RUNG, 1, 4'h0, 8'h10, 7'h00, 11'h001, 0, 4'h1, 8'h31},
      // the unused operation code must leave everything alone
      '{sse_op_t'(2'h3), 1, 4'h0, 8'h31, 7'h00, 11'h001, 0, 4'h1, 8'h40},
      '{SSE_OP_INIT, 1, 4'h1, 8'h00, 7'h41, 11'h000, 0, 4'h0, 8'h00},
      '{SSE_OP_INIT, 1, 4'h3, 8'hF0, 7'h40, 11'h000, 0, 4'h0, 8'h00}};
   sse_step_engine dut (
      .clk(clk),
      .reset_n(reset_n),
      .op_valid(op_valid),
      .op_code(op_code),
      .rung_in(rung_in),
      .init_slot(init_slot),
      .init_start(init_start),
      .init_len(init_len),
      .test_en(test_en),
      .test_idx(test_idx),
      .test_par(test_par),
      .adv_en(adv_en),
      .adv_idx(adv_idx),
      .done(done),
      .rung_out(rung_out),
      .test_out(test_out),
      .init_fired(init_fired),
      .len_err(len_err),
      .steps(steps)
   );
   task automatic chk(input logic [255:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %0h want %0h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("mismatches %0d of %0d", n_fail, n_tests);
      if (n_fail == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic step(input sse_row_t r);
      logic [10:0] b;
      @(posedge clk);
      op_valid <= r.op != SSE_OP_NONE;
      op_code <= r.op;
      rung_in <= r.rin;
      {init_slot, init_start, init_len} <= {r.sl, r.st, r.ln};
      {test_en, test_par, adv_en} <= {r.te, r.par, r.ae};
      for (int k = 0; k < 11; k++) test_idx[k*8+:8] <= 8'(r.st + k);
      for (int k = 0; k < 4; k++) adv_idx[k*8+:8] <= 8'(r.ab + k);
      #1;
      if (have) begin
         chk(done, e_dn);
         chk(steps, m);
         if (e_dn) begin
            chk(rung_out, e_r);
            chk(test_out, e_to);
            chk({init_fired, len_err}, {e_f, e_l});
         end
      end
      have = 1;
      e_dn = r.op inside {SSE_OP_INIT, SSE_OP_RUNG};
      {e_to, e_f, e_l, e_r} = {13'h0000, r.rin};
      for (int k = 0; k < 11; k++) b[k] = m[8'(r.st + k)];
      if (r.op == SSE_OP_INIT) begin
         // the edge memory updates even when the length is refused
         if (r.rin && !mem[r.sl]) begin
            e_l = r.ln < 1 || r.ln > 64;
            e_f = !e_l;
            for (int k = 0; k < r.ln && r.st + k < 256 && e_f; k++) m[r.st + k] = 0;
            if (e_f) m[r.st] = 1;
         end
         mem[r.sl] = r.rin;
      end else if (r.op == SSE_OP_RUNG) begin
         e_to = {11{r.rin}} & r.te & b;
         e_r = r.rin && (r.te == 0 || (r.par ? |(r.te & b) : &(~r.te | b)));
         for (int k = 0; k < 11; k++) if (e_r && r.te[k]) m[8'(r.st + k)] = 0;
         for (int k = 0; k < 4; k++) if (e_r && r.ae[k]) m[8'(r.ab + k)] = 1;
      end
   endtask
   initial forever #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 500) begin
         n_fail++;
         wrap_up;
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1;
      foreach (rows[i]) step(rows[i]);
      step('0);
      @(posedge clk) reset_n <= 0;
      repeat (2) @(posedge clk);
      #1;
      chk(steps, '0);
      chk({done, rung_out, test_out, init_fired, len_err}, '0);
      @(posedge clk) reset_n <= 1;
      {m, mem, have} = '0;
      step(rows[0]);
      step('0);
      wrap_up;
   end
endmodule // testbench
